// [logic/parity_error_side_log.v]
// Purpose: Side log of secondary bus parity and ECC errors
// Assumes: Error events come from same-clock bus logic, one-cycle pulses
// Notes: Sticky fields clear only on power-on reset or by software
//
// Notes on behaviour
// - The kind flag is 1 for a correctable ECC data error, 0 otherwise.
// - The kind flag loads with the data log and rearms on a valid clear.
// - The kind flag means something only while the valid flag is set.
// - The attribute parity field keeps the attribute phase parity bit.
// - Stored parity is the driven one when driving, else the sampled one.
// - The parity fields are meaningful only in PCI-X Mode 1.
// - Attribute parity loads with the header log on attribute errors only.
// - Parity fields hold until software clears the matching status bit.
// - The upper address field keeps second address phase parity.
// - A single address cycle stores zero in the upper address field.
// - Upper address parity loads with the header log on address errors.
// - Capturing a data log sets the valid flag; writing one clears it.
`timescale 1ns/1ps
`include "side_log_defs.vh"

module parity_error_side_log (
  // Clock, enable and resets
  input wire clk_i,
  input wire rst_i,
  input wire pwr_on_rst_i,
  input wire ce_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // Bus mode and direction
  input wire pcix_mode1_i,
  input wire driving_i,
  // Data error event
  input wire data_err_i,
  input wire data_err_corr_i,
  // Header log events
  input wire attr_err_i,
  input wire addr_err_i,
  input wire dual_addr_i,
  input wire attr_par_drv_i,
  input wire attr_par_rcv_i,
  input wire uaddr_par_drv_i,
  input wire uaddr_par_rcv_i,
  // Header status clears from the uncorrectable status register
  input wire attr_sts_clr_i,
  input wire addr_sts_clr_i,
  // Log state to the rest of the device
  output wire log_valid_o,
  output wire data_log_load_o,
  output wire header_log_load_o,
  // Interrupt
  output wire irq_o
);

  // ==========================================================
  // Sticky log state, cleared only by power-on reset or by software
  reg kind_r;
  reg attr_par_r;
  reg uaddr_par_r;
  reg log_valid_r;
  reg attr_held_r;
  reg addr_held_r;

  // Interrupt state and bus state
  reg [`EV_W-1:0] irq_sts_r;
  reg [`EV_W-1:0] irq_mask_r;
  reg [`ADDR_W-1:0] addr_r;
  reg wr_r;
  reg rd_r;
  reg [31:0] rdata_r;

  wire access;
  wire data_take;
  wire attr_take;
  wire addr_take;
  wire wr_log;
  wire clr_valid;
  wire rd_status;
  wire [31:0] log_word;
  wire [31:0] rd_word;

  // Pick the parity the device drove or the one it sampled
  function pick_par;
    input drv;
    input par_drv;
    input par_rcv;
    begin
      pick_par = drv ? par_drv : par_rcv;
    end
  endfunction

  // ==========================================================
  // Capture qualification
  // Load pulses stay low while the clock enable freezes the state
  assign data_take = ce_i & data_err_i & ~log_valid_r;
  assign attr_take = ce_i & attr_err_i & ~attr_held_r
    & pcix_mode1_i;
  assign addr_take = ce_i & addr_err_i & ~addr_held_r
    & pcix_mode1_i;
  assign data_log_load_o = data_take;
  assign header_log_load_o = attr_take | addr_take;

  // Bus decode: address phase access and status read, data phase log write
  assign access = hsel_i & hready_i & htrans_i[1];
  assign wr_log = wr_r & (addr_r == `OFS_SIDE_LOG);
  assign clr_valid = wr_log & hwdata_i[`BIT_LOG_VALID];
  assign rd_status = access & ~hwrite_i
    & (haddr_i[`ADDR_W-1:0] == `OFS_STATUS);

  // Data log side: kind flag and valid flag
  always @(posedge clk_i or posedge pwr_on_rst_i) begin
    if (pwr_on_rst_i) begin
      kind_r <= 1'b0;
      log_valid_r <= 1'b0;
    end else if (ce_i) begin
      if (data_take) begin
        kind_r <= data_err_corr_i;
        log_valid_r <= 1'b1;
      end else if (clr_valid) begin
        log_valid_r <= 1'b0;
      end
    end
  end

  // Header side parity fields, held until status clear
  always @(posedge clk_i or posedge pwr_on_rst_i) begin
    if (pwr_on_rst_i) begin
      attr_par_r <= 1'b0;
      uaddr_par_r <= 1'b0;
      attr_held_r <= 1'b0;
      addr_held_r <= 1'b0;
    end else if (ce_i) begin
      if (attr_take) begin
        attr_par_r <= pick_par(driving_i, attr_par_drv_i,
          attr_par_rcv_i);
        attr_held_r <= 1'b1;
      end else if (attr_sts_clr_i) begin
        attr_held_r <= 1'b0;
      end
      if (addr_take) begin
        uaddr_par_r <= dual_addr_i & pick_par(driving_i,
          uaddr_par_drv_i, uaddr_par_rcv_i);
        addr_held_r <= 1'b1;
      end else if (addr_sts_clr_i) begin
        addr_held_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt status: events set, a status read clears, set wins
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_sts_r <= {`EV_W{1'b0}};
      irq_mask_r <= `RST_MASK;
    end else if (ce_i) begin
      irq_sts_r <= (rd_status ? {`EV_W{1'b0}} : irq_sts_r)
        | {addr_take, attr_take, data_take};
      if (wr_r && addr_r == `OFS_MASK) begin
        irq_mask_r <= hwdata_i[`EV_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_sts_r & irq_mask_r);

  // ==========================================================
  // AHB-Lite slave: zero wait states, OKAY always
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_r <= {`ADDR_W{1'b0}};
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rdata_r <= `RST_WORD;
    end else if (ce_i) begin
      wr_r <= access & hwrite_i;
      rd_r <= access & ~hwrite_i;
      addr_r <= haddr_i[`ADDR_W-1:0];
      if (access && !hwrite_i) begin
        rdata_r <= rd_word;
      end
    end
  end

  // Read view of the side log: kind meaningful only while valid
  assign log_word = {13'h0000,
    kind_r & log_valid_r,
    attr_par_r, uaddr_par_r, 6'h00, log_valid_r, 9'h000};

  // Read mux for the address phase
  assign rd_word =
    (haddr_i[`ADDR_W-1:0] == `OFS_SIDE_LOG) ? log_word :
    (haddr_i[`ADDR_W-1:0] == `OFS_STATUS) ? {29'h0, irq_sts_r} :
    (haddr_i[`ADDR_W-1:0] == `OFS_MASK) ? {29'h0, irq_mask_r} :
    (haddr_i[`ADDR_W-1:0] == `OFS_CTRL) ?
      {30'h0, addr_held_r, attr_held_r} : 32'h0000_0000;

  assign hrdata_o = rdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign log_valid_o = log_valid_r;

endmodule // parity_error_side_log

// [logic/side_log_defs.vh]
// Purpose: Offsets, field positions and reset values for the side log block
// Assumes: AHB-Lite word-aligned register map, 32-bit data
// Notes: Definitions only
`ifndef SIDE_LOG_DEFS_VH
`define SIDE_LOG_DEFS_VH

// ============================================================
// Register byte addresses
`define OFS_SIDE_LOG 12'h154
`define OFS_STATUS 12'h158
`define OFS_MASK 12'h15C
`define OFS_CTRL 12'h160
`define ADDR_W 12

// ============================================================
// Field positions of the side log register
`define BIT_KIND 18
`define BIT_ATTR_PAR 17
`define BIT_UADDR_PAR 16
`define BIT_LOG_VALID 9

// ============================================================
// Interrupt status and mask bits
`define EV_DATA 0
`define EV_ATTR 1
`define EV_ADDR 2
`define EV_W 3

// ============================================================
// Reset values
`define RST_WORD 32'h0000_0000
`define RST_MASK 3'h0

// ============================================================
// AHB encodings
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3

`endif

// [verification/side_log_checker.sv]
// Purpose: Assertions on the side log ports
// Assumes: One clock, both resets active high
// Notes: Bound to the design top
`timescale 1ns/1ps
module side_log_checker (
  // Clock, resets, enable
  input wire clk_i,
  input wire rst_i,
  input wire pwr_on_rst_i,
  input wire ce_i,
  // Bus
  input wire hsel_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  // Events and log state
  input wire pcix_mode1_i,
  input wire data_err_i,
  input wire attr_err_i,
  input wire addr_err_i,
  input wire log_valid_o,
  input wire data_log_load_o,
  input wire header_log_load_o
);
  // ====
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || pwr_on_rst_i);
  chk_load_cond: assert property (data_log_load_o ==
    (data_err_i && ce_i && !log_valid_o)) else $error("bad data load");
  chk_load_once: assert property (log_valid_o |->
    !data_log_load_o) else $error("data log reloaded");
  chk_valid_set: assert property (data_log_load_o |=>
    log_valid_o) else $error("valid not set");
  chk_valid_rise: assert property ($rose(log_valid_o) |->
    $past(data_log_load_o)) else $error("valid rose alone");
  chk_valid_clear: assert property ($fell(log_valid_o) |->
    $past(hwdata_i[9])) else $error("valid fell alone");
  chk_hdr_cause: assert property (header_log_load_o |->
    pcix_mode1_i && (attr_err_i || addr_err_i)) else $error("bad hdr");
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus response");
  chk_read_hold: assert property ($changed(hrdata_o) |->
    $past(hsel_i && htrans_i[1] && !hwrite_i && hready_i))
    else $error("read data moved");
  // Main scenarios
  cov_data: cover property (data_log_load_o);
  cov_hdr: cover property (header_log_load_o);
  cov_clear: cover property ($fell(log_valid_o));
endmodule // side_log_checker

bind parity_error_side_log side_log_checker u_chk (.*);

// [verification/err_agent.sv]
// Purpose: Secondary bus agent raising error events
// Assumes: Calls start just after a rising edge
// Notes: Unselected parity line carries the inverse
`timescale 1ns/1ps
module err_agent (
  // Clock
  input wire clk_i,
  // Events
  output reg data_o = 1'b0,
  output reg corr_o = 1'b0,
  output reg attr_o = 1'b0,
  output reg addr_o = 1'b0,
  output reg dual_o = 1'b0,
  output reg drv_o = 1'b0,
  output reg pd_o = 1'b0,
  output reg pr_o = 1'b1
);
  // One-cycle data error pulse
  task data(input c);
    begin
      data_o <= 1'b1;
      corr_o <= c;
      @(posedge clk_i) data_o <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // Header error pulse, parity p on the active side
  task hdr(input a, input du, input dr, input p);
    begin
      attr_o <= a;
      addr_o <= !a;
      dual_o <= du;
      drv_o <= dr;
      pd_o <= dr ? p : !p;
      pr_o <= dr ? !p : p;
      @(posedge clk_i) attr_o <= 1'b0;
      addr_o <= 1'b0;
      @(posedge clk_i);
    end
  endtask
endmodule // err_agent

// [verification/parity_error_side_log_tb.sv]
// Purpose: Self-checking bench for the side log
// Assumes: Slave always ready
// Notes: Bus tasks start just after a rising edge
`timescale 1ns/1ps
`include "side_log_defs.vh"
module parity_error_side_log_tb;
  reg clk_i = 0, rst_i = 1, pwr_on_rst_i = 1, hsel_i = 0, hwrite_i = 0;
  reg pcix_mode1_i = 0, attr_sts_clr_i = 0, addr_sts_clr_i = 0;
  reg [31:0] haddr_i = 0, hwdata_i = 0;
  reg [1:0] htrans_i = 0;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, log_valid_o, data_log_load_o;
  wire header_log_load_o, irq_o, data_err_i, data_err_corr_i, attr_err_i;
  wire addr_err_i, dual_addr_i, driving_i, attr_par_drv_i, attr_par_rcv_i;
  reg ce_i = 1'b1;
  wire [2:0] hsize_i = 3'h2;
  wire hready_i = hreadyout_o;
  wire uaddr_par_drv_i = attr_par_drv_i;
  wire uaddr_par_rcv_i = attr_par_rcv_i;
  integer error_cnt = 0, total_checks = 0;
  parity_error_side_log dut (.*);
  err_agent ag (.clk_i(clk_i), .data_o(data_err_i), .corr_o(data_err_corr_i),
    .attr_o(attr_err_i), .addr_o(addr_err_i), .dual_o(dual_addr_i),
    .drv_o(driving_i), .pd_o(attr_par_drv_i), .pr_o(attr_par_rcv_i));
  always #5 clk_i = ~clk_i;
  // Verdict and run end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // Bounded wait for hready at a rising edge
  task wt;
    integer i;
    begin
      i = 0;
      @(posedge clk_i);
      while (hready_i !== 1'b1 && i < 20) begin
        @(posedge clk_i);
        i = i + 1;
      end
      if (i == 20) begin
        error_cnt = error_cnt + 1;
        print_verdict;
      end
    end
  endtask
  // One single word transfer, read data compared
  task bus(input w, input [11:0] a, input [31:0] d, input [31:0] e);
    begin
      hsel_i <= 1'b1;
      haddr_i <= {20'h0, a};
      htrans_i <= `HTRANS_NONSEQ;
      hwrite_i <= w;
      wt;
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      wt;
      if (!w) chk(hrdata_o, e);
    end
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    pwr_on_rst_i <= 0;
    bus(0, `OFS_SIDE_LOG, 0, 0);
    bus(0, 12'h200, 0, 0);
    bus(1, `OFS_MASK, 32'h7, 0);
    ag.data(1);
    chk(irq_o, 1);
    bus(0, `OFS_SIDE_LOG, 0, 32'h40200);
    bus(0, `OFS_STATUS, 0, 32'h1);
    chk(irq_o, 0);
    ag.data(0);
    bus(0, `OFS_SIDE_LOG, 0, 32'h40200);
    bus(1, `OFS_SIDE_LOG, 32'h200, 0);
    bus(0, `OFS_SIDE_LOG, 0, 0);
    ce_i <= 0;
    ag.data(1);
    ce_i <= 1;
    bus(0, `OFS_SIDE_LOG, 0, 0);
    ag.data(0);
    bus(0, `OFS_SIDE_LOG, 0, 32'h200);
    $display("data log test done");
    pcix_mode1_i <= 1;
    ag.hdr(1, 0, 1, 1);
    bus(0, `OFS_SIDE_LOG, 0, 32'h20200);
    ag.hdr(0, 1, 0, 1);
    bus(0, `OFS_SIDE_LOG, 0, 32'h30200);
    ag.hdr(1, 0, 1, 0);
    bus(0, `OFS_SIDE_LOG, 0, 32'h30200);
    attr_sts_clr_i <= 1;
    addr_sts_clr_i <= 1;
    @(posedge clk_i) attr_sts_clr_i <= 0;
    addr_sts_clr_i <= 0;
    ag.hdr(0, 0, 0, 1);
    bus(0, `OFS_SIDE_LOG, 0, 32'h20200);
    pcix_mode1_i <= 0;
    ag.hdr(1, 0, 0, 0);
    bus(0, `OFS_SIDE_LOG, 0, 32'h20200);
    rst_i <= 1;
    @(posedge clk_i) rst_i <= 0;
    bus(0, `OFS_SIDE_LOG, 0, 32'h20200);
    $display("header log test done");
    print_verdict;
  end
endmodule // parity_error_side_log_tb
